//--- core/csbd_regs.svh
// Opcode fields, flag positions and reset values for the compare/skip unit
// Assumes 24-bit instruction words and 16-bit data words
`ifndef CSBD_REGS_SVH
`define CSBD_REGS_SVH
`define CSBD_OP_HI        23
`define CSBD_OP_LO        15
`define CSBD_OPC_SEQ      9'h1cf
`define CSBD_OPC_SNE      9'h1ce
`define CSBD_OPC_SGT      9'h1cc
`define CSBD_OPC_SLT      9'h1cd
`define CSBD_OPC_DEC_HI   23
`define CSBD_OPC_DEC_LO   15
`define CSBD_OPC_DEC      9'h1da
`define CSBD_OPC_DAW_HI   23
`define CSBD_OPC_DAW_LO   4
`define CSBD_OPC_DAW      20'hfd400
`define CSBD_WB_HI        14
`define CSBD_WB_LO        11
`define CSBD_BW_CMP       10
`define CSBD_BW_DEC       14
`define CSBD_DST_DEC      13
`define CSBD_FADDR_HI     12
`define CSBD_FADDR_LO     0
`define CSBD_WS_HI        3
`define CSBD_WS_LO        0
`define CSBD_F_C          0
`define CSBD_F_Z          1
`define CSBD_F_OV         2
`define CSBD_F_N          3
`define CSBD_F_DC         4
`define CSBD_FLAGS_RST    5'h00
`define CSBD_DEFAULT_WORK_REG_IDX     4'h0
`define CSBD_BCD_LIM      4'h9
`define CSBD_BCD_ADD      4'h6
`define CSBD_ONE          16'h0001
`endif

//--- core/csbd_pkg.sv
// Types shared by the compare/skip/adjust/decrement unit
// Assumes csbd_regs.svh is on the include path
package csbd_pkg;
   typedef enum logic [1:0] {
      CSBD_RUN   = 2'b00,
      CSBD_KILL1 = 2'b01,
      CSBD_KILL2 = 2'b10
   } csbd_state_t;

   typedef struct packed {
      logic        wr_en;
      logic [3:0]  idx;
      logic        byte_hi;
      logic        is_byte;
      logic [15:0] data;
   } csbd_wr_t;

   typedef struct packed {
      logic        wr_en;
      logic [12:0] addr;
      logic        is_byte;
      logic [15:0] data;
   } csbd_mem_t;
endpackage

//--- core/csbd_cmp.sv
// Signed compare of two operands at byte or word width
// Purely combinational; fed from the working register file
`timescale 1ns/1ps
module csbd_cmp
   import csbd_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         is_byte,
   output logic              eq,
   output logic              gt,
   output logic              lt
);
   logic signed [W-1:0] sa;
   logic signed [W-1:0] sb;

   always_comb begin
      if (is_byte) begin
         sa = W'(signed'(a[7:0]));
         sb = W'(signed'(b[7:0]));
      end else begin
         sa = signed'(a);
         sb = signed'(b);
      end
      eq = (sa == sb);
      gt = (sa > sb);
      lt = (sa < sb);
   end
endmodule

//--- core/csbd_bcd.sv
// Packed BCD correction of the low byte of a word
// Purely combinational
`timescale 1ns/1ps
`include "csbd_regs.svh"
module csbd_bcd
   import csbd_pkg::*;
(
   input  wire logic [15:0] din,
   input  wire logic        half_ripple_bit,
   input  wire logic        top_ripple_bit,
   output logic      [15:0] dout,
   output logic             carry_out
);
   logic [4:0] lo;
   logic [4:0] hi;

   always_comb begin
      lo = {1'b0, din[3:0]};
      if (din[3:0] > `CSBD_BCD_LIM || half_ripple_bit) begin
         lo = lo + {1'b0, `CSBD_BCD_ADD};
      end
      hi = {1'b0, din[7:4]} + {4'h0, lo[4]};
      if (din[7:4] > `CSBD_BCD_LIM || top_ripple_bit) begin
         hi = hi + {1'b0, `CSBD_BCD_ADD};
      end
      dout = {din[15:8], hi[3:0], lo[3:0]};
      carry_out = hi[4];
   end
endmodule

//--- core/csbd_unit.sv
// Execution unit: compare-and-skip, BCD adjust, file decrement
// Assumes fetch gives one instruction word per cycle with exec_valid,
// register file reads are combinational, data memory read is combinational.
// Contract
// - Equal-skip opcode skips when both operands are equal.
// - Greater-skip compares signed and skips when first exceeds second.
// - Less-skip compares signed and skips when first is below second.
// - Unequal-skip skips whenever operands differ.
// - Taken skip discards prefetched instruction and runs an idle slot.
// - Compare-skip is one word; 1 cycle, 2 or 3 when skipping.
// - Compare-skip writes nothing and leaves all flags unchanged.
// - Width bit 0 means word, 1 means byte.
// - Four-bit fields pick both operands from W0 to W15 directly.
// - Low nibble above 9 or half ripple set gets plus 6.
// - High nibble above 9 or top ripple set gets plus 6.
// - BCD adjust changes only low byte; top ripple reports rollover.
// - BCD adjust is byte only, direct register, touches only top ripple.
// - File decrement subtracts one and updates all five flags.
// - Default work register is W0.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "csbd_regs.svh"
module csbd_unit
   import csbd_pkg::*;
#(
   parameter int DW = 16,
   parameter int IW = 24
) (
   input  wire logic          mclk,
   input  wire logic          nrst,
   input  wire logic          exec_valid,
   input  wire logic [IW-1:0] exec_word,
   input  wire logic          next_is_two_word,
   output logic [3:0]         rf_ra_idx,
   input  wire logic [DW-1:0] rf_ra_data,
   output logic [3:0]         rf_rb_idx,
   input  wire logic [DW-1:0] rf_rb_data,
   input  wire logic [DW-1:0] rf_w0_data,
   output logic [12:0]        mem_raddr,
   input  wire logic [DW-1:0] mem_rdata,
   output csbd_wr_t           rf_wr,
   output csbd_mem_t          mem_wr,
   output logic [4:0]         flag_holder,
   output logic               flush_slot,
   output logic               skip_active,
   output logic               busy
);
   typedef struct packed {
      csbd_state_t st;
      logic [4:0]  flags;
      csbd_wr_t    rw;
      csbd_mem_t   mw;
      logic        flush;
   } csbd_core_t;

   csbd_core_t cur;
   csbd_core_t next_cur;

   logic        is_seq;
   logic        is_sne;
   logic        is_sgt;
   logic        is_slt;
   logic        is_dec;
   logic        is_daw;
   logic        bsel;
   logic        eq;
   logic        gt;
   logic        lt;
   logic        skip_hit;
   logic [15:0] bcd_out;
   logic        bcd_c;
   logic [15:0] dsrc;
   logic [16:0] dres;
   logic [4:0]  hres;
   logic [15:0] dmerge;
   logic        dneg;
   logic        dzero;
   logic        dov;
   logic        dcarry;
   logic        dhalf;
   logic        daddr_hi;

   always_comb begin
      is_seq = exec_word[`CSBD_OP_HI:`CSBD_OP_LO] == `CSBD_OPC_SEQ;
      is_sne = exec_word[`CSBD_OP_HI:`CSBD_OP_LO] == `CSBD_OPC_SNE;
      is_sgt = exec_word[`CSBD_OP_HI:`CSBD_OP_LO] == `CSBD_OPC_SGT;
      is_slt = exec_word[`CSBD_OP_HI:`CSBD_OP_LO] == `CSBD_OPC_SLT;
      is_dec = exec_word[`CSBD_OPC_DEC_HI:`CSBD_OPC_DEC_LO]
               == `CSBD_OPC_DEC;
      is_daw = exec_word[`CSBD_OPC_DAW_HI:`CSBD_OPC_DAW_LO]
               == `CSBD_OPC_DAW;
      bsel   = exec_word[`CSBD_BW_CMP];
   end

   // Operand selection, direct addressing only
   always_comb begin
      rf_ra_idx = exec_word[`CSBD_WB_HI:`CSBD_WB_LO];
      rf_rb_idx = exec_word[`CSBD_WS_HI:`CSBD_WS_LO];
      mem_raddr = exec_word[`CSBD_FADDR_HI:`CSBD_FADDR_LO];
   end

   csbd_cmp #(
      .W (DW)
   ) u_cmp (
      .a       (rf_ra_data),
      .b       (rf_rb_data),
      .is_byte (bsel),
      .eq      (eq),
      .gt      (gt),
      .lt      (lt)
   );

   csbd_bcd u_bcd (
      .din             (rf_rb_data),
      .half_ripple_bit (cur.flags[`CSBD_F_DC]),
      .top_ripple_bit  (cur.flags[`CSBD_F_C]),
      .dout            (bcd_out),
      .carry_out       (bcd_c)
   );

   always_comb begin
      skip_hit = (is_seq && eq)
              || (is_sne && !eq)
              || (is_sgt && gt)
              || (is_slt && lt);
   end

   // Decrement datapath; byte mode picks the addressed byte
   always_comb begin
      daddr_hi = mem_raddr[0];
      if (exec_word[`CSBD_BW_DEC]) begin
         dsrc = daddr_hi ? {8'h00, mem_rdata[15:8]}
                         : {8'h00, mem_rdata[7:0]};
      end else begin
         dsrc = mem_rdata;
      end
      dres  = {1'b0, dsrc} - {1'b0, `CSBD_ONE};
      hres  = {1'b0, dsrc[3:0]} - 5'h01;
      dhalf = !hres[4];
      if (exec_word[`CSBD_BW_DEC]) begin
         dneg   = dres[7];
         dzero  = dres[7:0] == 8'h00;
         dov    = dsrc[7] && !dres[7];
         dcarry = dsrc[7:0] != 8'h00;
         dmerge = daddr_hi ? {dres[7:0], mem_rdata[7:0]}
                           : {mem_rdata[15:8], dres[7:0]};
      end else begin
         dneg   = dres[15];
         dzero  = dres[15:0] == 16'h0000;
         dov    = dsrc[15] && !dres[15];
         dcarry = dsrc != 16'h0000;
         dmerge = dres[15:0];
      end
   end

   always_comb begin
      next_cur = cur;
      next_cur.rw.wr_en = 1'b0;
      next_cur.mw.wr_en = 1'b0;
      next_cur.flush = 1'b0;
      unique case (cur.st)
         CSBD_RUN: begin
            if (exec_valid && skip_hit) begin
               next_cur.flush = 1'b1;
               next_cur.st = CSBD_KILL1;
            end else if (exec_valid && is_daw) begin
               next_cur.rw.wr_en = 1'b1;
               next_cur.rw.idx = exec_word[`CSBD_WS_HI:`CSBD_WS_LO];
               next_cur.rw.byte_hi = 1'b0;
               next_cur.rw.is_byte = 1'b1;
               next_cur.rw.data = bcd_out;
               if (bcd_c) begin
                  next_cur.flags[`CSBD_F_C] = 1'b1;
               end
            end else if (exec_valid && is_dec) begin
               next_cur.flags[`CSBD_F_C]  = dcarry;
               next_cur.flags[`CSBD_F_Z]  = dzero;
               next_cur.flags[`CSBD_F_OV] = dov;
               next_cur.flags[`CSBD_F_N]  = dneg;
               next_cur.flags[`CSBD_F_DC] = dhalf;
               if (exec_word[`CSBD_DST_DEC]) begin
                  next_cur.mw.wr_en = 1'b1;
                  next_cur.mw.addr = mem_raddr;
                  next_cur.mw.is_byte = exec_word[`CSBD_BW_DEC];
                  next_cur.mw.data = dmerge;
               end else begin
                  next_cur.rw.wr_en = 1'b1;
                  next_cur.rw.idx = `CSBD_DEFAULT_WORK_REG_IDX;
                  next_cur.rw.byte_hi = 1'b0;
                  next_cur.rw.is_byte = exec_word[`CSBD_BW_DEC];
                  next_cur.rw.data = exec_word[`CSBD_BW_DEC]
                     ? {rf_w0_data[15:8], dres[7:0]} : dres[15:0];
               end
            end
         end
         CSBD_KILL1: begin
            if (next_is_two_word) begin
               next_cur.flush = 1'b1;
               next_cur.st = CSBD_KILL2;
            end else begin
               next_cur.st = CSBD_RUN;
            end
         end
         CSBD_KILL2: begin
            next_cur.st = CSBD_RUN;
         end
         default: begin
            next_cur.st = CSBD_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cur <= '0;
         cur.st <= CSBD_RUN;
         cur.flags <= `CSBD_FLAGS_RST;
      end else begin
         cur <= next_cur;
      end
   end

   always_comb begin
      rf_wr = cur.rw;
      mem_wr = cur.mw;
      flag_holder = cur.flags;
      flush_slot = cur.flush;
      skip_active = cur.st != CSBD_RUN;
      busy = cur.st != CSBD_RUN;
   end
endmodule

//--- testbench/csbd_unit_props.sv
// Port checker for the compare/skip/adjust/decrement unit
// Bound into csbd_unit; one clock domain
`timescale 1ns/1ps
module csbd_unit_props
   import csbd_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic        exec_valid,
   input wire logic [23:0] exec_word,
   input wire logic        next_is_two_word,
   input wire logic [15:0] rf_ra_data,
   input wire logic [15:0] rf_rb_data,
   input wire csbd_wr_t    rf_wr,
   input wire csbd_mem_t   mem_wr,
   input wire logic [4:0]  flag_holder,
   input wire logic        flush_slot,
   input wire logic        busy,
   input wire logic        skip_active
);
   logic        tk, cmp, hit, sb, dec, daw;
   logic [15:0] a, b;
   assign tk = exec_valid && !busy;
   assign sb = exec_word[10];
   assign a = sb ? {{8{rf_ra_data[7]}}, rf_ra_data[7:0]} : rf_ra_data;
   assign b = sb ? {{8{rf_rb_data[7]}}, rf_rb_data[7:0]} : rf_rb_data;
   assign cmp = tk && exec_word[23:17] == 7'h73;
   assign dec = tk && exec_word[23:15] == 9'h1da;
   assign daw = tk && exec_word[23:4] == 20'hfd400;
   always_comb begin
      case (exec_word[16:15])
         2'b11:   hit = a == b;
         2'b10:   hit = a != b;
         2'b00:   hit = $signed(a) > $signed(b);
         default: hit = $signed(a) < $signed(b);
      endcase
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_kill2;
      flush_slot ##1 flush_slot;
   endsequence
   chk_skip_taken: assert property (
      cmp && hit |=> flush_slot && busy) else $error("skip missing");
   chk_skip_none: assert property (
      cmp && !hit |=> !flush_slot && !busy) else $error("false skip");
   chk_cmp_quiet: assert property (
      cmp |=> $stable(flag_holder) && !rf_wr.wr_en && !mem_wr.wr_en)
      else $error("compare changed state");
   chk_two_word: assert property (
      cmp && hit ##1 next_is_two_word |-> s_kill2 ##1 !busy)
      else $error("two-word skip wrong");
   chk_one_word: assert property (
      cmp && hit ##1 !next_is_two_word |=> !flush_slot && !busy)
      else $error("one-word skip wrong");
   chk_dec_default_work_reg: assert property (
      dec && !exec_word[13] |=> rf_wr.wr_en && rf_wr.idx == 4'h0
      && !mem_wr.wr_en) else $error("decrement to W0 wrong");
   chk_dec_file: assert property (
      dec && exec_word[13] |=> mem_wr.wr_en && !rf_wr.wr_en
      && mem_wr.addr == $past(exec_word[12:0]))
      else $error("decrement to file wrong");
   chk_daw_upper: assert property (
      daw |=> rf_wr.wr_en && rf_wr.idx == $past(exec_word[3:0])
      && rf_wr.data[15:8] == $past(rf_rb_data[15:8])
      && flag_holder[4:1] == $past(flag_holder[4:1]))
      else $error("adjust touched upper byte or flags");
   chk_daw_carry: assert property (
      daw && flag_holder[0] |=> flag_holder[0]) else $error("carry lost");
   chk_skip_level: assert property (
      cmp |=> skip_active == $past(hit)) else $error("skip level wrong");
endmodule
bind csbd_unit csbd_unit_props chk (.mclk, .nrst, .exec_valid, .exec_word,
   .next_is_two_word, .rf_ra_data, .rf_rb_data, .rf_wr, .mem_wr,
   .flag_holder, .flush_slot, .busy, .skip_active);

//--- testbench/csbd_rf_model.sv
// Working register file and data memory beside the unit
// Reads combinational, writes on the rising edge; 8 memory words
`timescale 1ns/1ps
module csbd_rf_model
   import csbd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic [3:0]  rf_ra_idx,
   input  wire logic [3:0]  rf_rb_idx,
   input  wire logic [12:0] mem_raddr,
   input  wire csbd_wr_t    rf_wr,
   input  wire csbd_mem_t   mem_wr,
   output logic      [15:0] rf_ra_data,
   output logic      [15:0] rf_rb_data,
   output logic      [15:0] rf_w0_data,
   output logic      [15:0] mem_rdata
);
   logic [15:0] rf [16];
   logic [15:0] mem [8];
   assign rf_ra_data = rf[rf_ra_idx];
   assign rf_rb_data = rf[rf_rb_idx];
   assign rf_w0_data = rf[0];
   assign mem_rdata = mem[mem_raddr[3:1]];
   always @(posedge mclk) begin
      if (rf_wr.wr_en) rf[rf_wr.idx] <= rf_wr.data;
      if (mem_wr.wr_en) mem[mem_wr.addr[3:1]] <= mem_wr.data;
   end
endmodule

//--- testbench/csbd_unit_tb.sv
// Self-checking bench for csbd_unit with register file model
// Expected writes and idle slots are queued and matched by a monitor
`timescale 1ns/1ps
module csbd_unit_tb
   import csbd_pkg::*;
;
   logic        mclk = 0;
   logic        nrst = 0;
   logic        exec_valid = 0;
   logic [23:0] exec_word = 0;
   logic        next_is_two_word = 0;
   logic [3:0]  ra, rb;
   logic [12:0] maddr;
   logic [15:0] rad, rbd, w0d, md;
   csbd_wr_t    rf_wr;
   csbd_mem_t   mem_wr;
   logic [4:0]  flag_holder;
   logic        flush_slot, skip_active, busy;
   logic [17:0] exp_q [$];
   logic [31:0] rnd = 32'hcaf9;
   int          n_fail = 0;
   int          total_checks = 0;
   always #5 mclk = ~mclk;
   csbd_unit uut (.mclk(mclk), .nrst(nrst), .exec_valid(exec_valid),
      .exec_word(exec_word), .next_is_two_word(next_is_two_word),
      .rf_ra_idx(ra), .rf_ra_data(rad), .rf_rb_idx(rb), .rf_rb_data(rbd),
      .rf_w0_data(w0d), .mem_raddr(maddr), .mem_rdata(md), .rf_wr(rf_wr),
      .mem_wr(mem_wr), .flag_holder(flag_holder), .flush_slot(flush_slot),
      .skip_active(skip_active), .busy(busy));
   csbd_rf_model p (.mclk(mclk), .rf_ra_idx(ra), .rf_rb_idx(rb),
      .mem_raddr(maddr), .rf_wr(rf_wr), .mem_wr(mem_wr),
      .rf_ra_data(rad), .rf_rb_data(rbd), .rf_w0_data(w0d),
      .mem_rdata(md));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   function automatic logic [17:0] pop();
      if (exp_q.size() == 0) return 18'h3ffff;
      return exp_q.pop_front();
   endfunction
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic op(input logic [23:0] w, input logic tw, input logic sk);
      @(posedge mclk);
      exec_valid <= 1'b1;
      exec_word <= w;
      @(posedge mclk);
      exec_valid <= 1'b0;
      next_is_two_word <= tw;
      if (sk) begin
         @(posedge mclk);
         next_is_two_word <= 1'b0;
         if (tw) @(posedge mclk);
      end
      #1;
   endtask
   // Monitor: each write or idle slot takes the oldest note
   always @(negedge mclk) begin
      if (rf_wr.wr_en !== 1'b0) check({2'd1, rf_wr.data}, pop());
      if (mem_wr.wr_en !== 1'b0) check({2'd2, mem_wr.data}, pop());
      if (flush_slot !== 1'b0) check({2'd3, 16'h0}, pop());
   end
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
   initial begin
      logic [15:0] a, b, v, x, r, w;
      logic [8:0]  t;
      logic [4:0]  fl;
      logic [3:0]  ia, ib;
      logic [1:0]  kd;
      logic        hit, sb, hb, d;
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         if (i < 16) p.rf[i] = rnd[15:0];
         else p.mem[i - 16] = rnd[31:16];
      end
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      fl = 5'h0;
      for (int i = 0; i < 64; i++) begin
         rnd = lfsr(rnd);
         {kd, sb, ib, ia} = rnd[10:0];
         a = p.rf[ia];
         if (rnd[12] && ia != ib)
            p.rf[ib] = {rnd[13] ? ~a[15:8] : a[15:8], a[7:0]};
         b = p.rf[ib];
         if (sb) begin
            a = {{8{a[7]}}, a[7:0]};
            b = {{8{b[7]}}, b[7:0]};
         end
         case (kd)
            2'd0: hit = $signed(a) > $signed(b);
            2'd1: hit = $signed(a) < $signed(b);
            2'd2: hit = a != b;
            default: hit = a == b;
         endcase
         if (hit) exp_q.push_back({2'd3, 16'h0});
         if (hit && rnd[11]) exp_q.push_back({2'd3, 16'h0});
         op({7'h73, kd, ia, sb, 6'h0, ib}, rnd[11], hit);
         check({13'h0, flag_holder}, {13'h0, fl});
      end
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         sb = rnd[0];
         hb = sb & rnd[4];
         v = p.mem[rnd[3:1]];
         if (rnd[5]) v = rnd[7] ? 16'h8000 : {2{rnd[6] ? 8'h80 : 8'h00}};
         p.mem[rnd[3:1]] = v;
         x = sb ? {8'h0, hb ? v[15:8] : v[7:0]} : v;
         r = x - 16'h1;
         fl = sb ? {x[3:0] != 0, r[7], x == 16'h80, r[7:0] == 0, x != 0}
                 : {x[3:0] != 0, r[15], x == 16'h8000, r == 0, x != 0};
         d = rnd[8];
         if (!d) exp_q.push_back({2'd1, sb ? {p.rf[0][15:8], r[7:0]} : r});
         else if (!sb) exp_q.push_back({2'd2, r});
         else exp_q.push_back({2'd2, hb ? {r[7:0], v[7:0]}
                                        : {v[15:8], r[7:0]}});
         op({9'h1da, sb, d, 9'h0, rnd[3:1], hb}, 1'b0, 1'b0);
         check({13'h0, flag_holder}, {13'h0, fl});
         w = p.rf[rnd[12:9]];
         t = {1'b0, w[7:0]} + ((w[3:0] > 4'h9 || fl[4]) ? 9'h6 : 9'h0);
         t = t + ((w[7:4] > 4'h9 || fl[0]) ? 9'h60 : 9'h0);
         fl[0] = fl[0] | t[8];
         exp_q.push_back({2'd1, w[15:8], t[7:0]});
         op({20'hfd400, rnd[12:9]}, 1'b0, 1'b0);
         check({13'h0, flag_holder}, {13'h0, fl});
      end
      repeat (4) @(posedge mclk);
      check(18'(exp_q.size()), 18'h0);
      complete_run();
   end
endmodule
